// ==== src/prc_device.sv ====
// module: device end, pci reset tree and power/sleep control
// Behaviour
// - pci module has external and internal reset
// - sleep controller resets pci after global reset
// - power-on or warm pin gives global reset
// - system asserts global and pci reset together
// - power-on also asserts pci external reset
// - latch straps when power-on/warm reset releases
// - pci outputs high impedance while in reset
// - host stops initiated pci transactions first
// - host clears six target window enables
// - host clears initiator and memory enables
// - host waits reset done, then reconfigures
// - no acknowledge until pci reconfigured
// - power-on resets all, internal reset held
// - warm reset spares emulation, tied to pci reset
// - after emulation reset, release after pin reset
// - software never re-resets pci after release; device still sets internal reset again on sw_pci_reset
// - watchdog reset unsafe while pci used
`timescale 1ns/1ns
module prc_device (
	input wire logic mclk,
	input wire logic nrst,
	prc_link_if.dev link,
	input wire logic emu_reset_req,
	input wire logic wdog_reset_req,
	input wire logic sw_pci_reset,
	input wire logic sw_pci_release,
	input wire logic [prc_pkg::PRC_WIN_N-1:0] cfg_window_en,
	input wire logic cfg_initiator_en,
	input wire logic cfg_mem_en,
	input wire logic [7:0] strap_pins,
	output logic global_reset,
	output logic pci_ext_reset,
	output logic pci_int_reset,
	output logic emu_logic_reset,
	output logic [7:0] strap_latched,
	output logic pci_configured
);
	import prc_pkg::*;

	logic por_s, warm_s, pci_reset_pin_s;
	logic emu_req_q, wdog_req_q;
	logic glob_src, ext_src, rel_edge;
	logic [3:0] hold_reg, hold_next;
	logic glob_reg, ext_reg, int_reg, emu_reg, done_reg;
	logic seen_ext_reg;
	logic cfg_ok;
	logic ack_reg, oe_reg;
	logic [7:0] strap_reg;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	prc_sync u_por (.mclk(mclk), .nrst(nrst), .d(link.por_n), .q(por_s));
	prc_sync u_warm (.mclk(mclk), .nrst(nrst), .d(link.warm_n), .q(warm_s));
	prc_sync u_pci_reset_pin (.mclk(mclk), .nrst(nrst),
		.d(link.pci_reset_pin_n), .q(pci_reset_pin_s));

	// ------------------------------------------------------------
	// reset source decode
	// ------------------------------------------------------------
	// internal requests are same-clock logic, so they need no sync
	assign emu_req_q = emu_reset_req;
	assign wdog_req_q = wdog_reset_req;
	assign glob_src = !por_s || !warm_s || emu_req_q || wdog_req_q;
	assign ext_src = !pci_reset_pin_s || !por_s;
	assign rel_edge = (hold_reg == 4'h1);
	assign hold_next = glob_src ? PRC_HOLD_W :
		(hold_reg != PRC_CNT_RST) ? hold_reg - 4'h1 : PRC_CNT_RST;
	assign cfg_ok = (cfg_window_en != PRC_WIN_RST) && cfg_initiator_en &&
		cfg_mem_en;

	// ------------------------------------------------------------
	// global reset stretch and pci reset tree
	// ------------------------------------------------------------
	// external reset leaves once its sources and the global sources drop; global reset stays on for the PRC_HOLD_W stretch
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hold_reg <= PRC_CNT_RST;
			glob_reg <= 1'b1;
			ext_reg <= 1'b1;
			emu_reg <= 1'b1;
		end else begin
			hold_reg <= hold_next;
			glob_reg <= glob_src || (hold_reg != PRC_CNT_RST);
			ext_reg <= ext_src || (ext_reg && glob_src);
			// emulation logic only sees power-on
			emu_reg <= !por_s;
		end
	end

	// internal reset: set by global reset, cleared only by software
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			int_reg <= 1'b1;
			seen_ext_reg <= 1'b0;
		end else begin
			if (glob_reg) begin
				int_reg <= 1'b1;
			end else if (sw_pci_reset && int_reg) begin
				int_reg <= 1'b1;
			end else if (sw_pci_reset && !int_reg) begin
				int_reg <= 1'b1;
			end else if (sw_pci_release && seen_ext_reg) begin
				int_reg <= 1'b0;
			end
			// release waits for an external reset since the last global
			if (ext_reg) begin
				seen_ext_reg <= 1'b1;
			end else if (glob_src && !ext_src) begin
				seen_ext_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// straps, reset done and pci target gating
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			strap_reg <= PRC_STRAP_RST;
			done_reg <= 1'b0;
			ack_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			if (rel_edge && (por_s && warm_s)) begin
				strap_reg <= strap_pins;
			end
			done_reg <= !glob_reg;
			// not configured after reset: silence gives master abort
			ack_reg <= link.pci_req && cfg_ok && !int_reg &&
				!ext_reg && !glob_reg;
			oe_reg <= !(int_reg || ext_reg || glob_reg) &&
				link.bus_park;
		end
	end

	assign global_reset = glob_reg;
	assign pci_ext_reset = ext_reg;
	assign pci_int_reset = int_reg;
	assign emu_logic_reset = emu_reg;
	assign strap_latched = strap_reg;
	assign pci_configured = ack_reg;
	assign link.reset_done_output = done_reg;
	assign link.pci_ack = ack_reg;
	assign link.pci_ad_oe = oe_reg;
endmodule

// ==== src/prc_pkg.sv ====
// package: constants and types for pci global reset coordination
package prc_pkg;
	// reset stretch after the last source lets go
	localparam int PRC_HOLD_NS = 200;
	localparam int PRC_CLK_NS = 20;
	localparam int PRC_HOLD_CYC = PRC_HOLD_NS / PRC_CLK_NS;
	localparam logic [3:0] PRC_HOLD_W = 4'(PRC_HOLD_CYC);
	localparam logic [3:0] PRC_CNT_RST = 4'h0;
	localparam int PRC_WIN_N = 6;
	localparam logic [5:0] PRC_WIN_RST = 6'h00;
	localparam logic [7:0] PRC_STRAP_RST = 8'h00;
	// host drives a reset for PRC_PULSE_W plus one cycles, then waits for done
	localparam int PRC_PULSE_NS = 400;
	localparam int PRC_PULSE_CYC = PRC_PULSE_NS / PRC_CLK_NS;
	localparam logic [4:0] PRC_PULSE_W = 5'(PRC_PULSE_CYC);
	localparam logic [4:0] PRC_PCNT_RST = 5'h00;

	typedef enum logic [2:0] {
		PRC_H_RUN,
		PRC_H_STOP,
		PRC_H_DISABLE,
		PRC_H_RESET,
		PRC_H_WAIT,
		PRC_H_CONFIG
	} prc_host_state_t;
endpackage

// ==== src/prc_link_if.sv ====
// interface: board-level reset wires between host and device
`timescale 1ns/1ns
interface prc_link_if;
	logic por_n;
	logic warm_n;
	logic pci_reset_pin_n;
	logic reset_done_output;
	logic bus_park;
	logic pci_req;
	logic pci_ack;
	logic pci_ad_oe;

	modport dev (
		input por_n,
		input warm_n,
		input pci_reset_pin_n,
		input bus_park,
		input pci_req,
		output reset_done_output,
		output pci_ack,
		output pci_ad_oe
	);

	modport host (
		output por_n,
		output warm_n,
		output pci_reset_pin_n,
		output bus_park,
		output pci_req,
		input reset_done_output,
		input pci_ack,
		input pci_ad_oe
	);
endinterface

// ==== src/prc_sync.sv ====
// module: two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module prc_sync (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	logic meta_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= 1'b1;
			q <= 1'b1;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ==== src/prc_host.sv ====
// module: host end, disconnect sequence and board reset drive
`timescale 1ns/1ns
module prc_host (
	input wire logic mclk,
	input wire logic nrst,
	prc_link_if.host link,
	input wire logic reset_req,
	input wire logic use_por,
	input wire logic txn_busy,
	output logic stop_txn,
	output logic clear_windows,
	output logic clear_cmd_bits,
	output logic reconfig,
	output logic host_idle,
	output logic host_pci_req
);
	import prc_pkg::*;

	prc_host_state_t state_reg, state_next;
	logic [4:0] pcnt_reg;
	logic done_s, busy_q;
	logic rst_drv, por_sel_reg;

	prc_sync u_done (.mclk(mclk), .nrst(nrst),
		.d(link.reset_done_output), .q(done_s));
	assign busy_q = txn_busy;

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PRC_H_RUN: if (reset_req) state_next = PRC_H_STOP;
			PRC_H_STOP: if (!busy_q) state_next = PRC_H_DISABLE;
			PRC_H_DISABLE: state_next = PRC_H_RESET;
			PRC_H_RESET: if (pcnt_reg == PRC_PCNT_RST) state_next = PRC_H_WAIT;
			PRC_H_WAIT: if (done_s) state_next = PRC_H_CONFIG;
			PRC_H_CONFIG: state_next = PRC_H_RUN;
		endcase
	end
	assign rst_drv = (state_next == PRC_H_RESET);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= PRC_H_RUN;
			pcnt_reg <= PRC_PCNT_RST;
			por_sel_reg <= 1'b0;
			link.por_n <= 1'b1;
			link.warm_n <= 1'b1;
			link.pci_reset_pin_n <= 1'b1;
			link.bus_park <= 1'b0;
			link.pci_req <= 1'b0;
			stop_txn <= 1'b0;
			clear_windows <= 1'b0;
			clear_cmd_bits <= 1'b0;
			reconfig <= 1'b0;
			host_idle <= 1'b1;
			host_pci_req <= 1'b0;
		end else begin
			state_reg <= state_next;
			if (state_reg == PRC_H_RUN && reset_req) begin
				por_sel_reg <= use_por;
			end
			pcnt_reg <= (state_next == PRC_H_RESET && state_reg != PRC_H_RESET) ?
				PRC_PULSE_W : (pcnt_reg != PRC_PCNT_RST) ?
				pcnt_reg - 5'h01 : PRC_PCNT_RST;
			// one source drives global and pci reset together
			link.por_n <= !(rst_drv && por_sel_reg);
			link.warm_n <= !(rst_drv && !por_sel_reg);
			link.pci_reset_pin_n <= !rst_drv;
			// bus never parked on the device around reset
			link.bus_park <= (state_next == PRC_H_RUN);
			link.pci_req <= (state_next == PRC_H_RUN) && !reset_req;
			stop_txn <= (state_next == PRC_H_STOP);
			clear_windows <= (state_next == PRC_H_DISABLE);
			clear_cmd_bits <= (state_next == PRC_H_DISABLE);
			reconfig <= (state_next == PRC_H_CONFIG);
			host_idle <= (state_next == PRC_H_RUN);
			// no watchdog or software re-reset issued
			host_pci_req <= link.pci_ack;
		end
	end
endmodule

// ==== tb/prc_link_sva.sv ====
// checker: timing relations on the board reset link
`timescale 1ns/1ns
module prc_link_sva (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic por_n,
	input wire logic warm_n,
	input wire logic pci_reset_pin_n,
	input wire logic reset_done_output,
	input wire logic bus_park,
	input wire logic pci_req,
	input wire logic pci_ack,
	input wire logic pci_ad_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// saturates so a stuck-low pin cannot wrap
	logic [5:0] low_cnt_reg;
	logic [5:0] low_cnt_next;
	assign low_cnt_next = pci_reset_pin_n ? 6'h00 :
		(low_cnt_reg == 6'h3F) ? low_cnt_reg : low_cnt_reg + 6'h01;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) low_cnt_reg <= 6'h00;
		else low_cnt_reg <= low_cnt_next;
	end
	sequence pin_low;
		$fell(pci_reset_pin_n);
	endsequence
	sequence pin_high;
		$rose(pci_reset_pin_n);
	endsequence
	a_pins_paired: assert property (
		$fell(pci_reset_pin_n) == ($fell(por_n) || $fell(warm_n)))
		else $error("pin reset not paired with global");
	a_no_park: assert property (pin_low |-> !bus_park)
		else $error("bus parked at reset");
	a_oe_off: assert property (
		!pci_reset_pin_n [*5] |-> !pci_ad_oe)
		else $error("pci outputs driven in reset");
	a_done_falls: assert property (
		pin_low |-> ##[1:5] !reset_done_output)
		else $error("done did not fall");
	a_done_holds: assert property (
		pin_high |-> !reset_done_output [*8])
		else $error("done rose too early");
	a_done_rises: assert property (
		pin_high |-> ##[10:16] reset_done_output)
		else $error("done did not rise");
	a_pulse_width: assert property (
		pin_high |-> low_cnt_reg >= 6'h13 && low_cnt_reg <= 6'h16)
		else $error("reset pulse width off");
	a_no_ack_reset: assert property (
		!reset_done_output [*2] |-> !pci_ack)
		else $error("ack while in reset");
	a_ack_after_req: assert property (
		$rose(pci_ack) |-> $past(pci_req))
		else $error("ack without request");
endmodule

// ==== tb/pci_global_reset_coordination_bench.sv ====
// bench: both link ends joined, fixed reset sequences with random straps, windows and enables
`timescale 1ns/1ns
module pci_global_reset_coordination_bench;
	import prc_pkg::*;
	logic mclk, nrst, emu_req, wdog_req, sw_rst, sw_rel, init_en, mem_en;
	logic req, por_sel, busy, global_reset, pci_ext_reset, pci_int_reset;
	logic emu_logic_reset, pci_configured;
	logic [5:0] win;
	logic [7:0] strap, strap_latched;
	int seed, n_fail, tests_run, cycles;
	prc_link_if link ();
	prc_device u_prc_device (.mclk(mclk), .nrst(nrst), .link(link),
		.emu_reset_req(emu_req), .wdog_reset_req(wdog_req),
		.sw_pci_reset(sw_rst), .sw_pci_release(sw_rel),
		.cfg_window_en(win), .cfg_initiator_en(init_en),
		.cfg_mem_en(mem_en), .strap_pins(strap),
		.global_reset(global_reset), .pci_ext_reset(pci_ext_reset),
		.pci_int_reset(pci_int_reset), .emu_logic_reset(emu_logic_reset),
		.strap_latched(strap_latched), .pci_configured(pci_configured));
	prc_host u_prc_host (.mclk(mclk), .nrst(nrst), .link(link),
		.reset_req(req), .use_por(por_sel), .txn_busy(busy),
		.stop_txn(), .clear_windows(), .clear_cmd_bits(), .reconfig(),
		.host_idle(), .host_pci_req());
	prc_link_sva u_prc_link_sva (.mclk(mclk), .nrst(nrst),
		.por_n(link.por_n), .warm_n(link.warm_n),
		.pci_reset_pin_n(link.pci_reset_pin_n),
		.reset_done_output(link.reset_done_output),
		.bus_park(link.bus_park), .pci_req(link.pci_req),
		.pci_ack(link.pci_ack), .pci_ad_oe(link.pci_ad_oe));
	task automatic cmp1(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, e, g);
		end
	endtask
	task automatic cmp8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", what, e, g);
		end
	endtask
	// sel 1 watches global reset, 0 the done pin
	task automatic wait_on(input bit sel, input logic v);
		int n = 0;
		// step past the edge first so a value launched there is settled
		@(negedge mclk);
		while ((sel ? global_reset : link.reset_done_output) !== v) begin
			@(negedge mclk);
			n++;
			if (n == 200) begin
				cmp1("wait", v, !v);
				break;
			end
		end
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// ceiling well above the longest expected run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		seed = 23;
		{nrst, emu_req, wdog_req, sw_rst, sw_rel, req, por_sel} = 7'h00;
		{init_en, mem_en, busy, win, strap} = 17'h00000;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		wait_on(0, 1'b1);
		// chip resets that never touch the external pci reset
		for (int j = 0; j < 2; j++) begin
			@(posedge mclk);
			{emu_req, wdog_req} <= j ? 2'h1 : 2'h2;
			wait_on(1, 1'b1);
			cmp1("ext", 1'b0, pci_ext_reset);
			cmp1("emu", 1'b0, emu_logic_reset);
			@(posedge mclk);
			{emu_req, wdog_req, sw_rel} <= 3'h1;
			wait_on(0, 1'b1);
			repeat (4) @(negedge mclk);
			cmp1("int", 1'b1, pci_int_reset);
			@(posedge mclk);
			sw_rel <= 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			strap <= 8'($random(seed));
			win <= 6'($random(seed));
			// release stays low until software releases after reset
			{init_en, mem_en} <= 2'($random(seed));
			{por_sel, busy, req} <= {i[0], 2'h3};
			@(posedge mclk);
			req <= 1'b0;
			repeat (5) @(negedge mclk);
			cmp1("pin", 1'b1, link.pci_reset_pin_n);
			@(posedge mclk);
			busy <= 1'b0;
			wait_on(1, 1'b1);
			cmp1("ext", 1'b1, pci_ext_reset);
			cmp1("emu", i[0], emu_logic_reset);
			cmp1("oe", 1'b0, link.pci_ad_oe);
			wait_on(0, 1'b0);
			wait_on(0, 1'b1);
			cmp8("strap", strap, strap_latched);
			cmp1("int", 1'b1, pci_int_reset);
			cmp1("cfg", 1'b0, pci_configured);
			@(posedge mclk);
			sw_rel <= 1'b1;
			repeat (4) @(negedge mclk);
			cmp1("rel", 1'b0, pci_int_reset);
			@(posedge mclk);
			sw_rel <= 1'b0;
		end
		@(posedge mclk);
		sw_rst <= 1'b1;
		repeat (4) @(negedge mclk);
		cmp1("swrst", 1'b1, pci_int_reset);
		complete_run();
	end
endmodule
